//--- hdl/efs_top.sv
/*
 * Fault supervisor of a 12 V electronic fuse with an AXI4-Lite register slave.
 * Assumes comparator results arrive asynchronously and the AXI master is on aclk.
 */
// Local design decisions: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module efs_top #(
    parameter logic [efs_pkg::TMR_W-1:0] HOLD_CYCLES  = efs_pkg::HOLD_CYCLES,
    parameter logic [efs_pkg::TMR_W-1:0] START_CYCLES = efs_pkg::START_CYCLES,
    parameter logic [efs_pkg::TMR_W-1:0] RETRY_CYCLES = efs_pkg::RETRY_CYCLES,
    parameter bit                        AUTO_RETRY   = 1'b0
) (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // AXI4-Lite slave
    input  wire logic [efs_pkg::ADDR_W-1:0]   awaddr,
    input  wire logic                         awvalid,
    output logic                              awready,
    input  wire logic [31:0]                  wdata,
    input  wire logic [3:0]                   wstrb,
    input  wire logic                         wvalid,
    output logic                              wready,
    output logic [1:0]                        bresp,
    output logic                              bvalid,
    input  wire logic                         bready,
    input  wire logic [efs_pkg::ADDR_W-1:0]   araddr,
    input  wire logic                         arvalid,
    output logic                              arready,
    output logic [31:0]                       rdata,
    output logic [1:0]                        rresp,
    output logic                              rvalid,
    input  wire logic                         rready,
    // Comparators and enable
    input  wire efs_pkg::efs_cmp_type         comparators,
    input  wire logic                         enable_discharge_input,
    // Open-drain flags, active low on the wire
    input  wire logic                         fault_free_flag_in,
    output logic                              fault_free_flag_out,
    output logic                              fault_free_flag_oe,
    input  wire logic                         overcurrent_flag_in,
    output logic                              overcurrent_flag_out,
    output logic                              overcurrent_flag_oe,
    // Power stage
    output logic                              gate_enable,
    output logic                              soft_start_discharge,
    // Interrupt
    output logic                              irq
);
    // ==========================================================
    // Declarations
    localparam logic [efs_pkg::TMR_W-1:0] HOLD_LAST  = HOLD_CYCLES - 1'b1;
    localparam logic [efs_pkg::TMR_W-1:0] START_LAST = START_CYCLES - 1'b1;
    localparam logic [efs_pkg::TMR_W-1:0] RETRY_LAST = RETRY_CYCLES - 1'b1;

    efs_pkg::efs_regs_type           st_reg;
    efs_pkg::efs_regs_type           st_next;
    efs_pkg::efs_cmp_type            c;
    logic                            en;
    logic                            gate_on;
    logic                            hold_exp;
    logic                            start_tmo;
    logic                            retry_due;
    logic [efs_pkg::CAUSE_W-1:0]     cause;
    logic [efs_pkg::EVT_W-1:0]       evt_set;
    logic [efs_pkg::EVT_W-1:0]       evt_clr;
    logic                            aw_have;
    logic                            w_have;
    logic                            wr_do;
    logic                            rd_do;
    logic [efs_pkg::ADDR_W-1:0]      wr_addr;
    logic [31:0]                     wr_data;
    logic [3:0]                      wr_strb;

    // ==========================================================
    // Decoded conditions
    // Only the second synchroniser stage is looked at
    assign c         = st_reg.s2.cmp; // RULE_19
    assign en        = st_reg.s2.en;
    assign gate_on   = (st_reg.state == efs_pkg::ST_START) || (st_reg.state == efs_pkg::ST_ON);
    assign hold_exp  = gate_on && c.limiting && (st_reg.hold == HOLD_LAST); // RULE_02
    assign start_tmo = (st_reg.state == efs_pkg::ST_START) && (st_reg.tmr == START_LAST)
                       && !c.out_above_90; // RULE_09
    assign retry_due = AUTO_RETRY && (st_reg.state == efs_pkg::ST_FAULT)
                       && (st_reg.tmr == RETRY_LAST); // RULE_15

    always_comb begin
        cause = '0;
        cause[efs_pkg::CS_THERMAL]    = c.over_temp; // RULE_03 RULE_05
        cause[efs_pkg::CS_SHORT]      = gate_on && c.short_circuit; // RULE_04
        cause[efs_pkg::CS_HOLD]       = hold_exp; // RULE_02
        cause[efs_pkg::CS_START]      = start_tmo; // RULE_09
        cause[efs_pkg::CS_GATE_LEAK]  = gate_on && c.gate_low; // RULE_11
        cause[efs_pkg::CS_OUT_LOW]    = (st_reg.state == efs_pkg::ST_ON) && !c.out_above_90; // RULE_13
        cause[efs_pkg::CS_GATE_SHORT] = c.uvlo_ok && c.gate_short; // RULE_13
        cause[efs_pkg::CS_PUMP]       = c.uvlo_ok && c.pump_error; // RULE_13
        cause[efs_pkg::CS_PULLDOWN]   = c.uvlo_ok && c.pulldown_error; // RULE_13
    end

    // ==========================================================
    // Bus handshake
    assign awready = !st_reg.aw_hold && !st_reg.bvalid;
    assign wready  = !st_reg.w_hold && !st_reg.bvalid;
    assign arready = !st_reg.rvalid;
    assign aw_have = st_reg.aw_hold || (awvalid && awready);
    assign w_have  = st_reg.w_hold || (wvalid && wready);
    assign wr_do   = aw_have && w_have;
    assign rd_do   = arvalid && arready;
    assign wr_addr = st_reg.aw_hold ? st_reg.aw_addr : awaddr;
    assign wr_data = st_reg.w_hold ? st_reg.wdata : wdata;
    assign wr_strb = st_reg.w_hold ? st_reg.wstrb : wstrb;
    // Only byte lane 0 carries writable register bits
    assign evt_clr = (wr_do && (wr_addr == efs_pkg::EVENT_OFFS) && wr_strb[0])
                     ? wr_data[efs_pkg::EVT_W-1:0] : '0;

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        evt_set = '0;
        st_next.s1.en      = enable_discharge_input; // RULE_19
        st_next.s1.ff_wire = fault_free_flag_in;
        st_next.s1.oc_wire = overcurrent_flag_in;
        st_next.s1.cmp     = comparators;
        st_next.s2         = st_reg.s1;

        // Hysteresis keeps the flag from chattering near the limit
        if (c.sense_above_85 || c.short_circuit) begin
            st_next.oc = 1'b1; // RULE_01 RULE_04
        end else if (c.sense_below_75) begin
            st_next.oc = 1'b0; // RULE_01 RULE_06
        end

        st_next.hold = (gate_on && c.limiting) ? st_reg.hold + 1'b1 : '0; // RULE_02 RULE_19

        if (!c.uvlo_ok) begin
            st_next.armed = 1'b0;
        end else if (!c.out_above_dsok) begin
            st_next.armed = 1'b1; // RULE_10
        end

        case (st_reg.state)
            efs_pkg::ST_OFF: begin
                st_next.tmr = '0;
                if (en && st_reg.armed && !c.out_above_dsok) begin
                    st_next.state = efs_pkg::ST_START; // RULE_12
                end
            end
            efs_pkg::ST_START: begin
                st_next.tmr = st_reg.tmr + 1'b1; // RULE_19
                if (!en) begin
                    st_next.state = efs_pkg::ST_OFF; // RULE_18
                end else if (c.out_above_90) begin
                    st_next.state = efs_pkg::ST_ON;
                    evt_set[efs_pkg::EVT_RUNNING] = 1'b1;
                end
            end
            efs_pkg::ST_ON: begin
                st_next.tmr = '0;
                if (!en) begin
                    st_next.state = efs_pkg::ST_OFF; // RULE_07 RULE_18
                end
            end
            efs_pkg::ST_FAULT: begin
                // Enable never ends a stored fault; it only picks whether a retry goes to ST_START or ST_OFF
                if (retry_due) begin
                    st_next.tmr   = '0;
                    st_next.state = en ? efs_pkg::ST_START : efs_pkg::ST_OFF; // RULE_15
                    evt_set[efs_pkg::EVT_RETRY] = 1'b1;
                end else if (AUTO_RETRY) begin
                    st_next.tmr = st_reg.tmr + 1'b1; // RULE_15 RULE_19
                end // RULE_14 RULE_16
            end
            default: begin
                st_next.state = efs_pkg::ST_OFF;
            end
        endcase

        if (|cause && (st_reg.state != efs_pkg::ST_FAULT)) begin
            st_next.state = efs_pkg::ST_FAULT; // RULE_02 RULE_03 RULE_09 RULE_11 RULE_13
            st_next.tmr   = '0;
            st_next.cause = st_reg.cause | cause;
            evt_set[efs_pkg::EVT_FAULT] = 1'b1;
        end
        // Heat restarts the off time, so a hot die never retries
        if (c.over_temp) begin
            st_next.state = efs_pkg::ST_FAULT; // RULE_05
            st_next.tmr   = '0;
            st_next.cause[efs_pkg::CS_THERMAL] = 1'b1;
        end else if (!c.uvlo_ok) begin
            st_next.state = efs_pkg::ST_OFF; // RULE_14 RULE_16 RULE_17
            st_next.tmr   = '0;
            st_next.cause = '0;
        end

        st_next.gate   = (st_next.state == efs_pkg::ST_START) || (st_next.state == efs_pkg::ST_ON);
        st_next.ssd    = !st_next.gate; // RULE_13
        st_next.ff_low = (st_next.state == efs_pkg::ST_FAULT) || !st_next.armed; // RULE_07 RULE_08

        if (st_next.oc && !st_reg.oc) begin
            evt_set[efs_pkg::EVT_OVERCUR] = 1'b1;
        end
        // A new event wins over a clear in the same cycle
        st_next.evt = (st_reg.evt & ~evt_clr) | evt_set;

        // ==========================================================
        // Register writes
        if (awvalid && awready) begin
            st_next.aw_hold = 1'b1;
            st_next.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            st_next.w_hold = 1'b1;
            st_next.wdata  = wdata;
            st_next.wstrb  = wstrb;
        end
        if (wr_do) begin
            st_next.aw_hold = 1'b0;
            st_next.w_hold  = 1'b0;
            st_next.bvalid  = 1'b1;
            st_next.bresp   = efs_pkg::RESP_OKAY;
            case (wr_addr)
                efs_pkg::STATUS_OFFS, efs_pkg::CAUSE_OFFS, efs_pkg::EVENT_OFFS: begin
                end
                efs_pkg::MASK_OFFS: begin
                    if (wr_strb[0]) begin
                        st_next.mask = wr_data[efs_pkg::EVT_W-1:0];
                    end
                end
                default: begin
                    st_next.bresp = efs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_reg.bvalid && bready) begin
            st_next.bvalid = 1'b0;
        end

        // ==========================================================
        // Register reads
        if (rd_do) begin
            st_next.rvalid = 1'b1;
            st_next.rresp  = efs_pkg::RESP_OKAY;
            st_next.rdata  = '0;
            case (araddr)
                efs_pkg::STATUS_OFFS: begin
                    st_next.rdata[efs_pkg::STATUS_W-1:0] = {st_reg.s2.oc_wire, st_reg.s2.ff_wire,
                        st_reg.ssd, st_reg.armed, st_reg.ff_low, st_reg.oc, st_reg.gate,
                        st_reg.state};
                end
                efs_pkg::CAUSE_OFFS: begin
                    st_next.rdata[efs_pkg::CAUSE_W-1:0] = st_reg.cause;
                end
                efs_pkg::EVENT_OFFS: begin
                    st_next.rdata[efs_pkg::EVT_W-1:0] = st_reg.evt;
                end
                efs_pkg::MASK_OFFS: begin
                    st_next.rdata[efs_pkg::EVT_W-1:0] = st_reg.mask;
                end
                default: begin
                    st_next.rresp = efs_pkg::RESP_SLVERR;
                end
            endcase
        end else if (st_reg.rvalid && rready) begin
            st_next.rvalid = 1'b0;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_reg        <= '0;
            st_reg.ff_low <= 1'b1;
            st_reg.ssd    <= 1'b1;
            st_reg.mask   <= efs_pkg::MASK_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign bvalid               = st_reg.bvalid;
    assign bresp                = st_reg.bresp;
    assign rvalid               = st_reg.rvalid;
    assign rdata                = st_reg.rdata;
    assign rresp                = st_reg.rresp;
    assign gate_enable          = st_reg.gate;
    assign soft_start_discharge = st_reg.ssd;
    assign fault_free_flag_out  = 1'b0;
    assign fault_free_flag_oe   = st_reg.ff_low;
    assign overcurrent_flag_out = 1'b0;
    assign overcurrent_flag_oe  = st_reg.oc;
    assign irq                  = |(st_reg.evt & st_reg.mask);

    // ==========================================================
    // Assertions
    default clocking efs_cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    property p_oc_set;
        c.sense_above_85 |=> overcurrent_flag_oe;
    endproperty
    a_oc_set: assert property (p_oc_set) else $error("overcurrent flag not pulled"); // RULE_01

    property p_oc_release;
        (c.sense_below_75 && !c.sense_above_85 && !c.short_circuit) |=> !overcurrent_flag_oe;
    endproperty
    a_oc_release: assert property (p_oc_release) else $error("overcurrent flag held"); // RULE_06

    property p_hold;
        (gate_on && c.limiting && st_reg.hold == HOLD_LAST && c.uvlo_ok)
            |=> (st_reg.state == efs_pkg::ST_FAULT) && !gate_enable && fault_free_flag_oe;
    endproperty
    a_hold: assert property (p_hold) else $error("hold expiry did not shut down"); // RULE_02

    property p_thermal;
        c.over_temp |=> (st_reg.state == efs_pkg::ST_FAULT) && !gate_enable
                        && fault_free_flag_oe;
    endproperty
    a_thermal: assert property (p_thermal) else $error("thermal shutdown missed"); // RULE_05

    property p_short;
        (c.short_circuit && gate_on && c.uvlo_ok) |=> !gate_enable && overcurrent_flag_oe;
    endproperty
    a_short: assert property (p_short) else $error("short circuit not handled"); // RULE_04

    property p_enable_off;
        (st_reg.state == efs_pkg::ST_ON && !en && c.uvlo_ok && cause == '0)
            |=> (st_reg.state == efs_pkg::ST_OFF) && !fault_free_flag_oe;
    endproperty
    a_enable_off: assert property (p_enable_off) else $error("enable shutdown flagged"); // RULE_07

    property p_uvlo_flag;
        !c.uvlo_ok |=> fault_free_flag_oe;
    endproperty
    a_uvlo_flag: assert property (p_uvlo_flag) else $error("flag released in lockout"); // RULE_08

    property p_start_tmo;
        (start_tmo && c.uvlo_ok) |=> (st_reg.state == efs_pkg::ST_FAULT)
                                     && st_reg.cause[efs_pkg::CS_START];
    endproperty
    a_start_tmo: assert property (p_start_tmo) else $error("start-up not aborted"); // RULE_09

    property p_dsok_block;
        (st_reg.state == efs_pkg::ST_OFF && c.out_above_dsok) |=> !gate_enable;
    endproperty
    a_dsok_block: assert property (p_dsok_block) else $error("start despite short"); // RULE_12

    property p_fault_outputs;
        (st_reg.state == efs_pkg::ST_FAULT) |-> soft_start_discharge && fault_free_flag_oe;
    endproperty
    a_fault_outputs: assert property (p_fault_outputs) else $error("fault outputs wrong"); // RULE_13

    property p_latch;
        (!AUTO_RETRY && st_reg.state == efs_pkg::ST_FAULT && c.uvlo_ok)
            |=> st_reg.state == efs_pkg::ST_FAULT;
    endproperty
    a_latch: assert property (p_latch) else $error("latched fault left"); // RULE_14

    property p_retry;
        (retry_due && !c.over_temp && c.uvlo_ok && en) |=> st_reg.state == efs_pkg::ST_START;
    endproperty
    a_retry: assert property (p_retry) else $error("retry did not restart"); // RULE_15

    property p_uvlo_clear;
        (!c.uvlo_ok && !c.over_temp) |=> (st_reg.state == efs_pkg::ST_OFF)
                                         && (st_reg.cause == '0) && !gate_enable;
    endproperty
    a_uvlo_clear: assert property (p_uvlo_clear) else $error("lockout did not clear"); // RULE_17
endmodule : efs_top

//--- hdl/efs_pkg.sv
/*
 * Shared constants, state encoding and carrier structs of the eFuse fault supervisor.
 * Assumes a 200 MHz aclk and digital comparator results from the analog front end.
 */
// Summary of operation
// RULE_01 - Overcurrent flag asserts above 85% of limit reference, releases below 75%.
// RULE_02 - Limiting starts a 250 us hold timer; expiry switches off, flags fault.
// RULE_03 - Die overtemperature near 140 C switches off and flags fault.
// RULE_04 - Short-circuit above 100 A shuts down at once and asserts overcurrent flag.
// RULE_05 - Thermal shutdown acts in every state and beats every other input.
// RULE_06 - Overcurrent flag stays released in start-up and normal run without overload.
// RULE_07 - Fault-free flag drops only for non-enable shutdowns, never for enable low.
// RULE_08 - Fault-free flag is held low while supply is under lockout.
// RULE_09 - Output below 90% of input after 200 ms aborts start-up as fault.
// RULE_10 - After lockout clears, fault-free flag releases only with output below threshold.
// RULE_11 - Gate-to-input difference below 5.6 V in start-up or run is a fault.
// RULE_12 - While disabled, output held high by a short blocks any new start-up.
// RULE_13 - Diagnosed faults drop fault-free flag and discharge the soft-start node.
// RULE_14 - Latching variant stays off after a fault until lockout or power cycle.
// RULE_15 - Auto-retry variant waits 1 s off, then restarts, with unlimited retries.
// RULE_16 - A stored fault ignores the enable input; only lockout clears it.
// RULE_17 - Supply below lockout switches off and clears stored fault state.
// RULE_18 - Controller drives enable high to run, low to shut the output down.
// RULE_19 - Comparators are synchronised; hold, start-up and retry timers are clock counters.
package efs_pkg;
    // ==========================================================
    // Timing
    localparam int CLK_PERIOD_NS = 5;
    localparam int HOLD_TIME_US  = 250;
    localparam int START_TIME_MS = 200;
    localparam int RETRY_TIME_MS = 1000;
    localparam int TMR_W         = 28;
    localparam logic [TMR_W-1:0] HOLD_CYCLES  =
        TMR_W'((HOLD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] START_CYCLES =
        TMR_W'((START_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] RETRY_CYCLES =
        TMR_W'((RETRY_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    // ==========================================================
    // Register map
    localparam int         ADDR_W      = 8;
    localparam logic [7:0] STATUS_OFFS = 8'h00;
    localparam logic [7:0] CAUSE_OFFS  = 8'h04;
    localparam logic [7:0] EVENT_OFFS  = 8'h08;
    localparam logic [7:0] MASK_OFFS   = 8'h0C;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam int         STATUS_W    = 9;
    localparam int EVT_W = 4, EVT_FAULT = 0, EVT_OVERCUR = 1, EVT_RUNNING = 2, EVT_RETRY = 3;
    localparam logic [EVT_W-1:0] MASK_RESET = 4'h0;
    localparam int CAUSE_W = 9, CS_THERMAL = 0, CS_SHORT = 1, CS_HOLD = 2, CS_START = 3;
    localparam int CS_GATE_LEAK = 4, CS_OUT_LOW = 5, CS_GATE_SHORT = 6, CS_PUMP = 7;
    localparam int CS_PULLDOWN = 8;
    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_OFF = 2'h0, ST_START = 2'h1, ST_ON = 2'h2, ST_FAULT = 2'h3
    } efs_state_type;
    typedef struct packed {
        logic uvlo_ok;        // Internal supply above lockout
        logic over_temp;      // Die at thermal threshold
        logic short_circuit;  // Load above short_circuit_limit
        logic sense_above_85; // Sense above 85% of limit_reference_input
        logic sense_below_75; // Sense below 75% of limit_reference_input
        logic limiting;       // Current limit loop active
        logic out_above_90;   // Output above 90% of input
        logic out_above_dsok; // Output above drain_source_ok_threshold
        logic gate_low;       // Gate-to-input below 5.6 V
        logic gate_short;     // Gate shorted to input
        logic pump_error;     // Charge pump error
        logic pulldown_error; // Pull-down circuit error
    } efs_cmp_type;
    typedef struct packed {
        logic        en;
        logic        ff_wire;
        logic        oc_wire;
        efs_cmp_type cmp;
    } efs_sync_type;
    typedef struct packed {
        efs_state_type      state;
        logic [TMR_W-1:0]   tmr;
        logic [TMR_W-1:0]   hold;
        efs_sync_type       s1;
        efs_sync_type       s2;
        logic               armed;
        logic               gate;
        logic               ff_low;
        logic               oc;
        logic               ssd;
        logic [CAUSE_W-1:0] cause;
        logic [EVT_W-1:0]   evt;
        logic [EVT_W-1:0]   mask;
        logic               aw_hold;
        logic [ADDR_W-1:0]  aw_addr;
        logic               w_hold;
        logic [31:0]        wdata;
        logic [3:0]         wstrb;
        logic               bvalid;
        logic [1:0]         bresp;
        logic               rvalid;
        logic [31:0]        rdata;
        logic [1:0]         rresp;
    } efs_regs_type;
endpackage : efs_pkg

//--- sim/efs_ctrl_model.sv
/*
 * System controller model: drives the enable input and reads the flags.
 * Assumes board pull-ups on both open-drain flags.
 */
`timescale 1ns/1ps
module efs_ctrl_model (
    // Controller request
    input  wire logic aclk,
    input  wire logic run,
    output logic      enable_discharge_input = 1'h0,
    // Open-drain flags
    input  wire logic ff_oe,
    input  wire logic oc_oe,
    output logic      ff_wire,
    output logic      oc_wire
);
    always @(posedge aclk) enable_discharge_input <= run;
    // Released flags float to the pull-up level, never to the last value
    assign ff_wire = !ff_oe;
    assign oc_wire = !oc_oe;
endmodule : efs_ctrl_model

//--- sim/efs_top_test.sv
/*
 * Self-checking bench of the fault supervisor, latching variant, short timers.
 * Assumes efs_pkg and the controller model are compiled first.
 */
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; \
    $display("FAIL %0t mismatch", $time); end end
module efs_top_test;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic rready = 0, run = 0, awready, wready, bvalid, arready, rvalid;
    logic ffoe, ocoe, gate, ssd, irq, en, ffw, ocw;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata;
    logic [3:0] wstrb = 4'hF, m;
    logic [1:0] bresp, rresp;
    logic [33:0] q[$], exp;
    efs_pkg::efs_cmp_type cmp = '0;
    int errors = 0, checked = 0, cyc = 0;
    efs_top #(.HOLD_CYCLES(28'h8), .START_CYCLES(28'h28), .RETRY_CYCLES(28'h14),
        .AUTO_RETRY(1'h0)) efs_top_i (.aclk, .aresetn, .awaddr, .awvalid, .awready,
        .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .comparators(cmp),
        .enable_discharge_input(en), .fault_free_flag_in(ffw), .fault_free_flag_out(),
        .fault_free_flag_oe(ffoe), .overcurrent_flag_in(ocw), .overcurrent_flag_out(),
        .overcurrent_flag_oe(ocoe), .gate_enable(gate), .soft_start_discharge(ssd), .irq);
    efs_ctrl_model efs_ctrl_model_i (.aclk, .run, .enable_discharge_input(en),
        .ff_oe(ffoe), .oc_oe(ocoe), .ff_wire(ffw), .oc_wire(ocw));
    always #2.5 aclk = ~aclk;
    // ==========================================================
    // Bus tasks and read-result monitor
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bit ad = 0, dd = 0;
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (awready && !ad) begin ad = 1; awvalid <= 0; end
            if (wready && !dd) begin dd = 1; wvalid <= 0; end
        end
        // Ready stays high between calls, so no step writes it twice
        do @(posedge aclk); while (!bvalid);
        `CHK(bresp, efs_pkg::RESP_OKAY)
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e); araddr <= a; arvalid <= 1; rready <= 1;
        do @(posedge aclk); while (!arready);
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
    endtask : rd
    task automatic settle;
        repeat (8) @(posedge aclk);
    endtask : settle
    always @(posedge aclk) if (rvalid && rready) begin
        exp = q.pop_front();
        `CHK({rresp, rdata}, exp)
    end
    task automatic wrap_up;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up
    // Hang guard, far above the few hundred cycles the tests need
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 3000) begin errors++; wrap_up(); end
    end
    // ==========================================================
    // Tests
    initial begin
        void'($urandom(80813));
        repeat (20) @(posedge aclk);
        aresetn <= 1; cmp.uvlo_ok <= 1; settle();
        `CHK(ffoe, 1'h0)
        rd(efs_pkg::MASK_OFFS, 34'h0);
        rd(8'h10, {efs_pkg::RESP_SLVERR, 32'h0});
        run <= 1; settle();
        `CHK(gate, 1'h1)
        cmp.out_above_90 <= 1; settle();
        rd(efs_pkg::STATUS_OFFS, 34'h1A6);
        $display("start test done");
        cmp.sense_above_85 <= 1; settle();
        `CHK(ocoe, 1'h1)
        cmp.sense_above_85 <= 0; settle();
        `CHK(ocoe, 1'h1)
        cmp.sense_below_75 <= 1; settle();
        `CHK(ocoe, 1'h0)
        run <= 0; settle();
        `CHK(gate, 1'h0)
        `CHK(ffoe, 1'h0)
        run <= 1; settle();
        $display("flag test done");
        cmp.limiting <= 1; repeat (4) @(posedge aclk);
        `CHK(gate, 1'h1)
        repeat (14) @(posedge aclk);
        `CHK(gate, 1'h0)
        `CHK(ssd, 1'h1)
        `CHK(ffoe, 1'h1)
        rd(efs_pkg::CAUSE_OFFS, 34'h4);
        cmp.limiting <= 0; run <= 0; settle(); run <= 1; settle();
        `CHK(gate, 1'h0)
        rd(efs_pkg::EVENT_OFFS, 34'h7);
        m = 4'($urandom());
        wr(efs_pkg::MASK_OFFS, {28'h0, m});
        `CHK(irq, |(m & 4'h7))
        wr(efs_pkg::EVENT_OFFS, 32'hF);
        `CHK(irq, 1'h0)
        $display("hold test done");
        cmp.uvlo_ok <= 0; settle();
        `CHK(ffoe, 1'h1)
        rd(efs_pkg::CAUSE_OFFS, 34'h0);
        cmp <= '0; settle(); cmp.uvlo_ok <= 1; cmp.out_above_dsok <= 1; settle();
        `CHK(gate, 1'h0)
        `CHK(ffoe, 1'h1)
        cmp.out_above_dsok <= 0; settle();
        `CHK(gate, 1'h1)
        // Output never reaches 90%, so the start-up timer must expire
        repeat (40) @(posedge aclk);
        `CHK(gate, 1'h0)
        `CHK(ffoe, 1'h1)
        rd(efs_pkg::CAUSE_OFFS, 34'h8);
        $display("start timeout test done");
        cmp <= '0; settle(); cmp.uvlo_ok <= 1; cmp.short_circuit <= 1; settle();
        `CHK(gate, 1'h0)
        `CHK(ocoe, 1'h1)
        rd(efs_pkg::CAUSE_OFFS, 34'h2);
        cmp <= '0; settle(); cmp.uvlo_ok <= 1; settle();
        `CHK(gate, 1'h1)
        cmp.over_temp <= 1; cmp.uvlo_ok <= 0; settle();
        `CHK(gate, 1'h0)
        `CHK(ffoe, 1'h1)
        rd(efs_pkg::CAUSE_OFFS, 34'h1);
        $display("thermal test done");
        wrap_up();
    end
endmodule : efs_top_test
